// ---- include/ivs_regs.vh ----
`ifndef IVS_REGS_VH
`define IVS_REGS_VH
// ****************************************************************
// Control and status registers
// ****************************************************************
`define IVS_MCU_CONTROL_ADDR  8'h00
`define IVS_STATUS_ADDR       8'h01
`define IVS_MCU_CONTROL_RESET 8'h00
`define IVS_SEL_BIT           1
`define IVS_CE_BIT            0
`define IVS_MCU_CONTROL_MASK  8'h03
// ****************************************************************
// Timing and vectors
// ****************************************************************
`define IVS_CE_CYCLES         3'd4
`define IVS_RESET_VECTOR      16'h0000
`define IVS_VECTOR_BASE       16'h0002
`define IVS_NUM_SOURCES       37
`endif

// ---- verilog/ivs_vector_select.v ----
`timescale 1ns/1ns
`include "ivs_regs.vh"

module ivs_vector_select #(
  parameter ADDR_W = 16,
  parameter NSRC   = `IVS_NUM_SOURCES
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire              clk_en,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  input  wire [NSRC-1:0]   irq_pending,
  input  wire              global_int_enable,
  input  wire              instr_done,
  input  wire              exec_in_boot,
  input  wire              boot_reset_fuse,
  input  wire [ADDR_W-1:0] boot_start_addr,
  input  wire              app_section_boot_lock,
  input  wire              boot_section_self_lock,
  output reg               irq_request,
  output reg  [ADDR_W-1:0] irq_vector_addr,
  output reg  [5:0]        irq_vector_num,
  output reg  [ADDR_W-1:0] reset_vector_addr,
  output reg               vector_table_select,
  output reg               irq_masked
);

  // ****************************************************************
  // Change sequence states
  // ****************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_OPEN = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] ce_cnt_q;
  reg [2:0] ce_cnt_d;
  reg       sel_q;
  reg       sel_d;
  reg       hold_instr_q;
  reg       hold_instr_d;

  wire ctl_wr  = reg_wr && (reg_addr == `IVS_MCU_CONTROL_ADDR);
  wire wr_ce   = reg_wdata[`IVS_CE_BIT];
  wire wr_sel  = reg_wdata[`IVS_SEL_BIT];
  wire ce_live = (state_q == ST_OPEN);

  // ****************************************************************
  // Change enable and select sequencing
  // ****************************************************************
  always @* begin
    state_d      = state_q;
    ce_cnt_d     = ce_cnt_q;
    sel_d        = sel_q;
    hold_instr_d = hold_instr_q;
    case (state_q)
      ST_IDLE: begin
        if (ctl_wr && wr_ce) begin
          state_d  = ST_OPEN;
          ce_cnt_d = `IVS_CE_CYCLES - 3'd1;
        end
      end
      ST_OPEN: begin
        if (ctl_wr && !wr_ce) begin
          sel_d        = wr_sel;
          state_d      = ST_HOLD;
          hold_instr_d = 1'b0;
        end else if (ctl_wr && wr_ce) begin
          ce_cnt_d = `IVS_CE_CYCLES - 3'd1;
        end else if (ce_cnt_q == 3'd0) begin
          state_d = ST_IDLE;
        end else begin
          ce_cnt_d = ce_cnt_q - 3'd1;
        end
      end
      ST_HOLD: begin
        // Wait for the write's own instruction end, then the next one
        if (instr_done) begin
          if (hold_instr_q) begin
            state_d = ST_IDLE;
          end else begin
            hold_instr_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_q      <= ST_IDLE;
      ce_cnt_q     <= 3'd0;
      sel_q        <= 1'b0;
      hold_instr_q <= 1'b0;
    end else if (clk_en) begin
      state_q      <= state_d;
      ce_cnt_q     <= ce_cnt_d;
      sel_q        <= sel_d;
      hold_instr_q <= hold_instr_d;
    end
  end

  // ****************************************************************
  // Priority encoder and vector address
  // ****************************************************************
  reg [5:0] pick;
  reg       any;
  integer   i;
  always @* begin
    pick = 6'd0;
    any  = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (irq_pending[i]) begin
        pick = i[5:0];
        any  = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Vector table, word offsets from the table start
  // ****************************************************************
  // Spelled out per source so a gap in the table cannot hide in arithmetic
  reg [6:0] tbl_off;
  always @* begin
    tbl_off = 7'h00;
    case (pick)
      // External requests 0..7
      6'h00: begin
        tbl_off = 7'h02;
      end
      6'h01: begin
        tbl_off = 7'h04;
      end
      6'h02: begin
        tbl_off = 7'h06;
      end
      6'h03: begin
        tbl_off = 7'h08;
      end
      6'h04: begin
        tbl_off = 7'h0A;
      end
      6'h05: begin
        tbl_off = 7'h0C;
      end
      6'h06: begin
        tbl_off = 7'h0E;
      end
      6'h07: begin
        tbl_off = 7'h10;
      end
      // Pin change group zero
      6'h08: begin
        tbl_off = 7'h12;
      end
      // USB general, USB endpoint, watchdog
      6'h09: begin
        tbl_off = 7'h14;
      end
      6'h0A: begin
        tbl_off = 7'h16;
      end
      6'h0B: begin
        tbl_off = 7'h18;
      end
      // Timer 2
      6'h0C: begin
        tbl_off = 7'h1A;
      end
      6'h0D: begin
        tbl_off = 7'h1C;
      end
      6'h0E: begin
        tbl_off = 7'h1E;
      end
      // Timer 1
      6'h0F: begin
        tbl_off = 7'h20;
      end
      6'h10: begin
        tbl_off = 7'h22;
      end
      6'h11: begin
        tbl_off = 7'h24;
      end
      6'h12: begin
        tbl_off = 7'h26;
      end
      6'h13: begin
        tbl_off = 7'h28;
      end
      // Timer 0
      6'h14: begin
        tbl_off = 7'h2A;
      end
      6'h15: begin
        tbl_off = 7'h2C;
      end
      6'h16: begin
        tbl_off = 7'h2E;
      end
      // Serial peripheral transfer complete
      6'h17: begin
        tbl_off = 7'h30;
      end
      // Serial port receive, buffer empty, transmit done
      6'h18: begin
        tbl_off = 7'h32;
      end
      6'h19: begin
        tbl_off = 7'h34;
      end
      6'h1A: begin
        tbl_off = 7'h36;
      end
      // Comparator, converter, nonvolatile data
      6'h1B: begin
        tbl_off = 7'h38;
      end
      6'h1C: begin
        tbl_off = 7'h3A;
      end
      6'h1D: begin
        tbl_off = 7'h3C;
      end
      // Timer 3
      6'h1E: begin
        tbl_off = 7'h3E;
      end
      6'h1F: begin
        tbl_off = 7'h40;
      end
      6'h20: begin
        tbl_off = 7'h42;
      end
      6'h21: begin
        tbl_off = 7'h44;
      end
      6'h22: begin
        tbl_off = 7'h46;
      end
      // Two-wire interface, program store ready
      6'h23: begin
        tbl_off = 7'h48;
      end
      6'h24: begin
        tbl_off = 7'h4A;
      end
      default: begin
        tbl_off = 7'h00;
      end
    endcase
  end

  wire [ADDR_W-1:0] table_addr = {{(ADDR_W-7){1'b0}}, tbl_off};
  wire [ADDR_W-1:0] base_addr  = sel_q ? boot_start_addr : {ADDR_W{1'b0}};
  wire [ADDR_W-1:0] vec_addr   = table_addr + base_addr;

  // ****************************************************************
  // Interrupt masking
  // ****************************************************************
  reg seq_mask;
  reg lock_mask;
  always @* begin
    seq_mask = 1'b0;
    // Mask from the very cycle the enable write is taken
    if (ctl_wr && wr_ce && (state_q == ST_IDLE)) begin
      seq_mask = 1'b1;
    end
    if (ce_live || (state_q == ST_HOLD)) begin
      seq_mask = 1'b1;
    end
  end

  always @* begin
    lock_mask = 1'b0;
    // Vectors in boot space while application code runs
    if (sel_q && app_section_boot_lock && !exec_in_boot) begin
      lock_mask = 1'b1;
    end
    // Vectors in application space while boot code runs
    if (!sel_q && boot_section_self_lock && exec_in_boot) begin
      lock_mask = 1'b1;
    end
  end

  wire mask_d = seq_mask || lock_mask;

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always @(posedge mclk) begin
    if (reset) begin
      irq_request         <= 1'b0;
      irq_vector_addr     <= {ADDR_W{1'b0}};
      irq_vector_num      <= 6'd0;
      reset_vector_addr   <= `IVS_RESET_VECTOR;
      vector_table_select <= 1'b0;
      irq_masked          <= 1'b0;
      reg_rdata           <= 8'h00;
    end else if (clk_en) begin
      // Global enable is only read here, never altered
      irq_request         <= any && global_int_enable && !mask_d;
      irq_vector_addr     <= vec_addr;
      irq_vector_num      <= pick + 6'd2;
      reset_vector_addr   <= boot_reset_fuse ? `IVS_RESET_VECTOR : boot_start_addr;
      vector_table_select <= sel_d;
      irq_masked          <= mask_d;
      if (reg_rd) begin
        case (reg_addr)
          `IVS_MCU_CONTROL_ADDR: reg_rdata <= {6'b000000, sel_q, ce_live} & `IVS_MCU_CONTROL_MASK;
          `IVS_STATUS_ADDR:      reg_rdata <= {5'b00000, state_q};
          default:               reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // ivs_vector_select

// ---- tb/ivs_vector_select_checker.sv ----
`timescale 1ns/1ns
module ivs_vector_select_checker #(parameter ADDR_W = 16, parameter NSRC = 37) (
  input wire              mclk,
  input wire              reset,
  input wire [7:0]        reg_addr,
  input wire [7:0]        reg_wdata,
  input wire              reg_wr,
  input wire [NSRC-1:0]   irq_pending,
  input wire              exec_in_boot,
  input wire              boot_reset_fuse,
  input wire [ADDR_W-1:0] boot_start_addr,
  input wire              app_section_boot_lock,
  input wire              boot_section_self_lock,
  input wire              irq_request,
  input wire [ADDR_W-1:0] irq_vector_addr,
  input wire [5:0]        irq_vector_num,
  input wire [ADDR_W-1:0] reset_vector_addr,
  input wire              vector_table_select,
  input wire              irq_masked
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  function automatic [5:0] low_vec(input [NSRC-1:0] p);
    low_vec = 6'd0;
    for (int k = NSRC - 1; k >= 0; k--)
      if (p[k]) low_vec = 6'(k + 2);
  endfunction
  sequence ce_set; reg_wr && reg_addr == 8'h00 && reg_wdata[0]; endsequence
  sequence quiet; !reg_wr && !app_section_boot_lock && !boot_section_self_lock; endsequence
  a_reset_vector: assert property (!$past(reset) |-> reset_vector_addr ==
    ($past(boot_reset_fuse) ? 16'h0000 : $past(boot_start_addr))) else $error("reset vector wrong");
  a_select_guard: assert property ($changed(vector_table_select) |->
    $past(reg_wr && reg_addr == 8'h00 && irq_masked)) else $error("select changed unguarded");
  a_ce_masks: assert property (ce_set |=> irq_masked) else $error("no mask after enable");
  a_mask_lapse: assert property (ce_set ##1 quiet [*6] |-> !irq_masked) else $error("mask too long");
  a_mask_blocks: assert property (irq_masked |-> !irq_request) else $error("request while masked");
  a_vector_prio: assert property (irq_request |-> irq_vector_num == low_vec($past(irq_pending)))
    else $error("wrong vector number");
  a_vector_addr: assert property (irq_request |-> irq_vector_addr ==
    ($past(vector_table_select) ? $past(boot_start_addr) : 16'h0000) + (irq_vector_num - 6'd1) * 16'd2)
    else $error("wrong vector address");
  a_lock_app: assert property ($past(vector_table_select && app_section_boot_lock && !exec_in_boot)
    |-> !irq_request) else $error("request in locked application");
  a_lock_boot: assert property ($past(!vector_table_select && boot_section_self_lock && exec_in_boot)
    |-> !irq_request) else $error("request in locked boot code");
endmodule // ivs_vector_select_checker

// ---- tb/ivs_core_model.sv ----
`timescale 1ns/1ns
module ivs_core_model #(parameter PER = 2) (
  input  wire mclk,
  input  wire reset,
  output reg  instr_done
);
  // Ends one instruction every PER cycles
  reg [3:0] cnt_q;
  always @(posedge mclk) begin
    cnt_q <= (reset || cnt_q == PER - 1) ? 4'h0 : cnt_q + 4'h1;
    instr_done <= !reset && cnt_q == PER - 1;
  end
endmodule // ivs_core_model

// ---- tb/ivs_vector_select_tb.sv ----
`timescale 1ns/1ns
module ivs_vector_select_tb;
  localparam logic [15:0] BOOT = 16'h7000;
  logic        mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, instr_done, req, sel, masked;
  logic        boot_reset_fuse = 0, app_section_boot_lock = 0, boot_section_self_lock = 0, exec_in_boot = 0;
  logic        gie = 1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [36:0] pend = '0;
  logic [15:0] vaddr, rvec;
  logic [5:0]  vnum;
  int          fails = 0, n_tests = 0;
  ivs_vector_select dut_u (.mclk(mclk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pending(pend), .global_int_enable(gie),
    .instr_done(instr_done), .exec_in_boot(exec_in_boot), .boot_reset_fuse(boot_reset_fuse),
    .boot_start_addr(BOOT), .app_section_boot_lock(app_section_boot_lock),
    .boot_section_self_lock(boot_section_self_lock), .irq_request(req), .irq_vector_addr(vaddr),
    .irq_vector_num(vnum), .reset_vector_addr(rvec), .vector_table_select(sel), .irq_masked(masked));
  ivs_core_model #(.PER(2)) core_u (.mclk(mclk), .reset(reset), .instr_done(instr_done));
  always #20 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    cyc(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1; reg_addr <= a;
    cyc(1);
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    logic [7:0] d;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    cyc(1);
    chk(rvec, BOOT);
    boot_reset_fuse <= 1'b1;
    rd(8'h00, d);
    chk({8'h00, d}, 16'h0000);
    chk(rvec, 16'h0000);
    cyc(1);
    rd(8'h05, d);
    chk({8'h00, d}, 16'h0000);
    $display("reset and register test done");
    for (int k = 0; k < 37; k++) begin
      pend <= {37{1'b1}} << k;
      cyc(2);
      chk({10'h000, vnum}, 16'(k + 2));
      chk(vaddr, 16'(2 * k + 2));
    end
    $display("vector table test done");
    boot_section_self_lock <= 1'b1; exec_in_boot <= 1'b1; pend <= 37'h1;
    cyc(2);
    chk({15'h0, req}, 16'h0000);
    exec_in_boot <= 1'b0;
    cyc(2);
    chk({15'h0, req}, 16'h0001);
    gie <= 1'b0;
    cyc(2);
    chk({15'h0, req}, 16'h0000);
    gie <= 1'b1;
    boot_section_self_lock <= 1'b0;
    wr(8'h00, 8'h02);
    cyc(1);
    chk({15'h0, sel}, 16'h0000);
    wr(8'h00, 8'h01);
    chk({15'h0, masked}, 16'h0001);
    cyc(1);
    wr(8'h00, 8'h02);
    chk({14'h0, sel, req}, 16'h0002);
    cyc(8);
    chk({15'h0, req}, 16'h0001);
    chk(vaddr, BOOT + 16'h0002);
    app_section_boot_lock <= 1'b1;
    cyc(2);
    chk({15'h0, req}, 16'h0000);
    app_section_boot_lock <= 1'b0;
    wr(8'h00, 8'h01);
    rd(8'h00, d);
    chk({8'h00, d}, 16'h0003);
    cyc(5);
    wr(8'h00, 8'h00);
    cyc(1);
    chk({14'h0, sel, masked}, 16'h0002);
    $display("relocation test done");
    complete_run;
  end
  initial begin
    #100000;
    fails++;
    complete_run;
  end
endmodule // ivs_vector_select_tb
bind ivs_vector_select ivs_vector_select_checker #(.ADDR_W(ADDR_W), .NSRC(NSRC)) chk_u (.mclk(mclk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .irq_pending(irq_pending),
  .exec_in_boot(exec_in_boot), .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(boot_start_addr),
  .app_section_boot_lock(app_section_boot_lock), .boot_section_self_lock(boot_section_self_lock),
  .irq_request(irq_request), .irq_vector_addr(irq_vector_addr), .irq_vector_num(irq_vector_num),
  .reset_vector_addr(reset_vector_addr), .vector_table_select(vector_table_select), .irq_masked(irq_masked));
